// File: logic/pbc_pkg.sv
// shared constants for the port b pin control block
package pbc_pkg;
    localparam int PBC_WIDTH = 8;
    // pins that carry a change enable: 7..4 and 2..0
    localparam logic [7:0] PBC_IOC_IMPL = 8'hf7;
    // pins that carry a weak pull-up: 7..4 and 2..1
    localparam logic [7:0] PBC_WPU_IMPL = 8'hf6;
    localparam logic [7:0] PBC_IOC_RESET = 8'h00;
    localparam logic [7:0] PBC_WPU_RESET = 8'h00;
    localparam logic [7:0] PBC_ANSEL_RESET = 8'hff;
    localparam logic [7:0] PBC_DIR_RESET = 8'hff;
    localparam logic [7:0] PBC_LATCH_RESET = 8'h00;
    localparam logic PBC_GPU_DIS_RESET = 1'b1;
    localparam int PBC_PIN_ZERO = 0;
    localparam int PBC_PIN_ONE = 1;
    localparam int PBC_PIN_CSENSE = 1;
    typedef enum logic [1:0] {
        PBC_SRC_NONE,
        PBC_SRC_I2C,
        PBC_SRC_LATCH
    } pbc_src_t;
endpackage : pbc_pkg

// File: logic/pbc_sync2.sv
// two-flop synchroniser for the pin inputs
`timescale 1ns/1ns
module pbc_sync2 #(
    parameter int WIDTH = 8
) (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] stage1;

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            // pads reset high: an i2c line idles high, a low reset would fake a start
            stage1 <= '1;
            sync_o <= '1;
        end else begin
            stage1 <= async_i;
            sync_o <= stage1;
        end
    end
endmodule : pbc_sync2

// File: logic/pbc_port_b.sv
// port b pin control: change enables, pull-ups, analog gating, output priority
// How it works
// [R1] each pin has its own change enable, with pins 7..4 and 2..0 implemented and pin 3 without.
// [R2] a reset clears every change enable so no pin raises a change event until software sets it.
// [R3] every pin except pins 0 and 3 has its own pull-up enable, implemented on pins 7..4 and 2..1.
// [R4] a pin driven as an output always has its pull-up forced off whatever its enable says.
// [R5] after reset the global pull-up disable bit is set and holds every pull-up off.
// [R6] an analog-selected pin reads back 0 on every digital read and lets analog functions run; the i2c slave data input on pin 0 stays live.
// [R7] analog select never touches the output path, so an analog output pin still drives data.
// [R8] analog select bits come out of reset set and software clears them for digital input use.
// [R9] pin 0 is open drain: it may only pull low and never drives high.
// [R10] when several output functions are enabled on a pin, the highest priority one wins.
// [R11] on pin 0 the i2c master data output beats the port latch and both drive open drain.
// [R12] pin 0 feeds the i2c slave data input with a selectable i2c or smbus input level.
// [R13] selecting the adc channel four input on pin 1 blocks its digital buffer and reads 0.
// [R14] analog inputs stay connected in analog mode while digital outputs still drive by priority.
// [R15] a direction bit of 1 means input with driver off and 0 means output with driver on.
// [R16] a port read returns pin states and a port write updates the output latch.
// [R17] each enabled pin compares its read value (0 when analog-selected) with the previous sample every clock.
`timescale 1ns/1ns
module pbc_port_b
    import pbc_pkg::*;
#(
    parameter int WIDTH = PBC_WIDTH
) (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // software write strobes with data
    input wire logic change_irq_enable_b_we_i,
    input wire logic [WIDTH-1:0] change_irq_enable_b_wdata_i,
    input wire logic pullup_enable_b_we_i,
    input wire logic [WIDTH-1:0] pullup_enable_b_wdata_i,
    input wire logic global_pullup_disable_we_i,
    input wire logic global_pullup_disable_wdata_i,
    input wire logic analog_select_b_we_i,
    input wire logic [WIDTH-1:0] analog_select_b_wdata_i,
    input wire logic direction_b_we_i,
    input wire logic [WIDTH-1:0] direction_b_wdata_i,
    input wire logic port_b_value_we_i,
    input wire logic [WIDTH-1:0] port_b_value_wdata_i,
    // peripheral side
    input wire logic i2c_master_sda_en_i,
    input wire logic i2c_master_sda_low_i,
    input wire logic i2c_smbus_level_i,
    // pads
    input wire logic [WIDTH-1:0] pad_in_i,
    output logic [WIDTH-1:0] pad_out_o,
    output logic [WIDTH-1:0] pad_oe_o,
    output logic [WIDTH-1:0] pad_pullup_o,
    output logic [WIDTH-1:0] pad_dig_buf_en_o,
    output logic pad_sda_smbus_level_o,
    // readback and events
    output logic [WIDTH-1:0] change_irq_enable_b_o,
    output logic [WIDTH-1:0] pullup_enable_b_o,
    output logic global_pullup_disable_o,
    output logic [WIDTH-1:0] analog_select_b_o,
    output logic [WIDTH-1:0] direction_b_o,
    output logic [WIDTH-1:0] port_b_latch_o,
    output logic [WIDTH-1:0] port_b_value_o,
    output logic i2c_slave_sda_o,
    output logic adc_channel_four_input_o,
    output logic [WIDTH-1:0] change_event_o
);
    logic [WIDTH-1:0] pin_sync;
    logic [WIDTH-1:0] pin_prev;
    logic [WIDTH-1:0] next_read;
    logic [WIDTH-1:0] next_out;
    logic [WIDTH-1:0] next_oe;
    logic [WIDTH-1:0] next_pullup;
    pbc_src_t pin0_src;

    function automatic logic [WIDTH-1:0] masked(input logic [WIDTH-1:0] v,
                                                input logic [WIDTH-1:0] impl);
        masked = v & impl;
    endfunction : masked

    pbc_sync2 #(
        .WIDTH(WIDTH)
    ) u_sync (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .async_i(pad_in_i),
        .sync_o(pin_sync)
    );

    // configuration registers
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            change_irq_enable_b_o <= PBC_IOC_RESET; // [R2]
        end else if (change_irq_enable_b_we_i) begin
            change_irq_enable_b_o <= masked(change_irq_enable_b_wdata_i, PBC_IOC_IMPL); // [R1]
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pullup_enable_b_o <= PBC_WPU_RESET;
        end else if (pullup_enable_b_we_i) begin
            pullup_enable_b_o <= masked(pullup_enable_b_wdata_i, PBC_WPU_IMPL); // [R3]
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            global_pullup_disable_o <= PBC_GPU_DIS_RESET; // [R5]
        end else if (global_pullup_disable_we_i) begin
            global_pullup_disable_o <= global_pullup_disable_wdata_i;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            analog_select_b_o <= PBC_ANSEL_RESET; // [R8]
        end else if (analog_select_b_we_i) begin
            analog_select_b_o <= analog_select_b_wdata_i;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            direction_b_o <= PBC_DIR_RESET;
        end else if (direction_b_we_i) begin
            direction_b_o <= direction_b_wdata_i;
        end
    end

    // software does read-modify-write on the whole byte; the latch takes it as given
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            port_b_latch_o <= PBC_LATCH_RESET;
        end else if (port_b_value_we_i) begin
            port_b_latch_o <= port_b_value_wdata_i; // [R16]
        end
    end

    // pin 0 owner: i2c master first, then the port latch when the direction is output
    always_comb begin
        if (i2c_master_sda_en_i) begin
            pin0_src = PBC_SRC_I2C; // [R10] [R11]
        end else if (!direction_b_o[PBC_PIN_ZERO]) begin
            pin0_src = PBC_SRC_LATCH;
        end else begin
            pin0_src = PBC_SRC_NONE;
        end
    end

    // analog select is deliberately absent from the output terms
    always_comb begin
        next_out = port_b_latch_o; // [R7] [R14]
        next_oe = ~direction_b_o; // [R15]
        // open drain: output value is always low, the enable carries the data
        next_out[PBC_PIN_ZERO] = 1'b0; // [R9]
        unique case (pin0_src)
            PBC_SRC_I2C: next_oe[PBC_PIN_ZERO] = i2c_master_sda_low_i; // [R11]
            PBC_SRC_LATCH: next_oe[PBC_PIN_ZERO] = ~port_b_latch_o[PBC_PIN_ZERO]; // [R9]
            PBC_SRC_NONE: next_oe[PBC_PIN_ZERO] = 1'b0;
            default: next_oe[PBC_PIN_ZERO] = 1'b0;
        endcase
    end

    always_comb begin
        next_pullup = masked(pullup_enable_b_o & direction_b_o, PBC_WPU_IMPL); // [R3] [R4]
        if (global_pullup_disable_o) begin
            next_pullup = '0; // [R5]
        end
    end

    // analog pins read zero; an output pin still reflects the pad level
    assign next_read = pin_sync & ~analog_select_b_o; // [R6] [R13]

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pad_out_o <= '0;
            pad_oe_o <= '0;
            pad_pullup_o <= '0;
            pad_dig_buf_en_o <= '0;
            pad_sda_smbus_level_o <= 1'b0;
        end else begin
            pad_out_o <= next_out;
            pad_oe_o <= next_oe;
            pad_pullup_o <= next_pullup;
            pad_dig_buf_en_o <= ~analog_select_b_o; // [R13]
            pad_sda_smbus_level_o <= i2c_smbus_level_i; // [R12]
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            port_b_value_o <= '0;
            i2c_slave_sda_o <= 1'b1;
            adc_channel_four_input_o <= 1'b0;
        end else begin
            port_b_value_o <= next_read; // [R16] [R6]
            // the slave input stays live even when pin 0 is analog-selected
            i2c_slave_sda_o <= pin_sync[PBC_PIN_ZERO]; // [R12] [R14]
            adc_channel_four_input_o <= analog_select_b_o[PBC_PIN_ONE]; // [R13]
        end
    end

    // change detection on the gated read value, so analog pins stay quiet
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_prev <= '0;
            change_event_o <= '0;
        end else begin
            pin_prev <= next_read;
            change_event_o <= (next_read ^ pin_prev) & change_irq_enable_b_o; // [R17]
        end
    end

    // assertions
    sequence s_pull_request;
        !global_pullup_disable_o && pullup_enable_b_o[PBC_PIN_ONE] && direction_b_o[PBC_PIN_ONE];
    endsequence

    a_ioc_pin_three: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [R1]
        (change_irq_enable_b_o & ~PBC_IOC_IMPL) == '0)
        else $error("pin 3 change enable set");

    a_ioc_reset_clear: assert property (@(posedge core_clk_i) // [R2]
        $rose(rst_n_i) |-> change_irq_enable_b_o == '0)
        else $error("change enables not clear after reset");

    a_pullup_pin_zero: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [R3]
        pad_pullup_o[PBC_PIN_ZERO] == 1'b0)
        else $error("pin 0 pull-up active");

    a_pullup_output_off: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [R4]
        !direction_b_o[PBC_PIN_ONE] |=> !pad_pullup_o[PBC_PIN_ONE])
        else $error("pull-up on an output pin");

    a_pullup_global_off: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [R5]
        global_pullup_disable_o |=> pad_pullup_o == '0)
        else $error("pull-up on while globally disabled");

    a_pullup_enabled_on: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [R3]
        s_pull_request |=> pad_pullup_o[PBC_PIN_ONE])
        else $error("requested pull-up missing");

    a_analog_read_zero: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [R6]
        analog_select_b_o[PBC_PIN_ONE] |=> !port_b_value_o[PBC_PIN_ONE])
        else $error("analog pin read non-zero");

    a_analog_out_drive: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [R7]
        (analog_select_b_o[PBC_PIN_ONE] && !direction_b_o[PBC_PIN_ONE]) |=>
        pad_oe_o[PBC_PIN_ONE] && pad_out_o[PBC_PIN_ONE] == $past(port_b_latch_o[PBC_PIN_ONE]))
        else $error("analog output pin not driving");

    a_ansel_reset_set: assert property (@(posedge core_clk_i) // [R8]
        $rose(rst_n_i) |-> analog_select_b_o == PBC_ANSEL_RESET)
        else $error("analog select not set after reset");

    a_open_drain_low: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [R9]
        pad_out_o[PBC_PIN_ZERO] == 1'b0)
        else $error("pin 0 driven high");

    a_i2c_wins_pin0: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [R11]
        (i2c_master_sda_en_i && !i2c_master_sda_low_i) |=> !pad_oe_o[PBC_PIN_ZERO])
        else $error("latch overrode i2c master on pin 0");

    a_change_event: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [R17]
        (change_irq_enable_b_o[PBC_PIN_ONE] && next_read[PBC_PIN_ONE] != pin_prev[PBC_PIN_ONE])
        |=> change_event_o[PBC_PIN_ONE])
        else $error("change event missed");

    a_event_unimpl_quiet: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [R1]
        (change_event_o & ~PBC_IOC_IMPL) == '0)
        else $error("change event on a pin without enable");

    a_wpu_unimpl_clear: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [R3]
        (pullup_enable_b_o & ~PBC_WPU_IMPL) == '0)
        else $error("pull-up enable set on a pin without pull-up");

    a_input_no_drive: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [R15]
        direction_b_o[PBC_PIN_ONE] |=> !pad_oe_o[PBC_PIN_ONE])
        else $error("input pin driven");

    a_read_follows_pin: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [R16]
        (!analog_select_b_o[PBC_PIN_ONE] && pin_sync[PBC_PIN_ONE]) |=>
        port_b_value_o[PBC_PIN_ONE])
        else $error("digital read lost the pin level");

    a_dig_buf_gate: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [R13]
        analog_select_b_o[PBC_PIN_ONE] |=> !pad_dig_buf_en_o[PBC_PIN_ONE])
        else $error("digital buffer on for analog pin");

    a_adc4_select: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [R13]
        analog_select_b_o[PBC_PIN_ONE] |=> adc_channel_four_input_o)
        else $error("adc channel four input not selected");

    a_smbus_level: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [R12]
        i2c_smbus_level_i |=> pad_sda_smbus_level_o)
        else $error("smbus input level not applied");

    a_sda_in_analog: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [R14]
        (analog_select_b_o[PBC_PIN_ZERO] && !pin_sync[PBC_PIN_ZERO]) |=> !i2c_slave_sda_o)
        else $error("slave data input cut off in analog mode");

    a_i2c_pull_pin0: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [R11]
        (i2c_master_sda_en_i && i2c_master_sda_low_i) |=> pad_oe_o[PBC_PIN_ZERO])
        else $error("i2c master pull-down missing on pin 0");

    a_latch_drive_pin0: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [R9]
        (!i2c_master_sda_en_i && !direction_b_o[PBC_PIN_ZERO]) |=>
        pad_oe_o[PBC_PIN_ZERO] == !$past(port_b_latch_o[PBC_PIN_ZERO]))
        else $error("pin 0 latch drive wrong");
endmodule : pbc_port_b

// File: verif/pbc_board_model.sv
// board model: resolves each pad from device drive, pull-ups and external drivers
`timescale 1ns/1ns
module pbc_board_model (
    input wire logic core_clk_i,
    input wire logic [7:0] pad_out_i,
    input wire logic [7:0] pad_oe_i,
    input wire logic [7:0] pad_pullup_i,
    input wire logic [7:0] ext_en_i,
    input wire logic [7:0] ext_val_i,
    output logic [7:0] pad_level_o
);
    logic [7:0] float_pat = 8'h55;
    // an unpulled, undriven pad wanders; a steady value would hide a missing drive
    always @(posedge core_clk_i) begin
        float_pat <= ~float_pat;
    end
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (pad_oe_i[i]) begin
                pad_level_o[i] = pad_out_i[i];
            end else if (ext_en_i[i]) begin
                pad_level_o[i] = ext_val_i[i];
            end else if (pad_pullup_i[i] || i == 0) begin
                // pin 0 sits on an i2c line with a board pull-up
                pad_level_o[i] = 1'b1;
            end else begin
                pad_level_o[i] = float_pat[i];
            end
        end
    end
endmodule : pbc_board_model

// File: verif/pbc_port_b_bench.sv
// self-checking bench for the port b pin control block
`timescale 1ns/1ns
module pbc_port_b_bench;
    import pbc_pkg::*;
    localparam int IOC = 0, WPU = 1, GPD = 2, ANS = 3, DIR = 4, LAT = 5;
    logic core_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [5:0] we = 6'h00;
    logic [7:0] wd = 8'h00;
    logic i2c_en = 1'b0, i2c_low = 1'b0, smbus = 1'b0;
    logic [7:0] ext_en = 8'hff, ext_val = 8'hff;
    logic [7:0] pad_lvl, pad_out, pad_oe, pad_pu, buf_en, ioc_o, wpu_o, ans_o, dir_o, lat_o;
    logic [7:0] val_o, ev_o;
    logic smb_o, gpd_o, sda_o, adc4_o;
    int n_errors = 0, n_tests = 0, cycles = 0;

    pbc_port_b u_dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
        .change_irq_enable_b_we_i(we[IOC]), .change_irq_enable_b_wdata_i(wd),
        .pullup_enable_b_we_i(we[WPU]), .pullup_enable_b_wdata_i(wd),
        .global_pullup_disable_we_i(we[GPD]), .global_pullup_disable_wdata_i(wd[0]),
        .analog_select_b_we_i(we[ANS]), .analog_select_b_wdata_i(wd),
        .direction_b_we_i(we[DIR]), .direction_b_wdata_i(wd),
        .port_b_value_we_i(we[LAT]), .port_b_value_wdata_i(wd),
        .i2c_master_sda_en_i(i2c_en), .i2c_master_sda_low_i(i2c_low),
        .i2c_smbus_level_i(smbus), .pad_in_i(pad_lvl), .pad_out_o(pad_out),
        .pad_oe_o(pad_oe), .pad_pullup_o(pad_pu), .pad_dig_buf_en_o(buf_en),
        .pad_sda_smbus_level_o(smb_o), .change_irq_enable_b_o(ioc_o),
        .pullup_enable_b_o(wpu_o), .global_pullup_disable_o(gpd_o),
        .analog_select_b_o(ans_o), .direction_b_o(dir_o), .port_b_latch_o(lat_o),
        .port_b_value_o(val_o), .i2c_slave_sda_o(sda_o),
        .adc_channel_four_input_o(adc4_o), .change_event_o(ev_o));

    pbc_board_model u_board (.core_clk_i(core_clk_i), .pad_out_i(pad_out),
        .pad_oe_i(pad_oe), .pad_pullup_i(pad_pu), .ext_en_i(ext_en),
        .ext_val_i(ext_val), .pad_level_o(pad_lvl));

    initial begin
        forever #5 core_clk_i = ~core_clk_i;
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : give_verdict

    // generous ceiling: the whole sequence needs well under a thousand cycles
    always @(posedge core_clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            n_errors++;
            $display("timeout after %0d cycles", cycles);
            give_verdict();
        end
    end

    task automatic settle();
        repeat (5) @(negedge core_clk_i);
    endtask : settle

    task automatic wr(input int r, input logic [7:0] d);
        @(negedge core_clk_i);
        we[r] = 1'b1;
        wd = d;
        @(negedge core_clk_i);
        we[r] = 1'b0;
        settle();
    endtask : wr

    task automatic chk(input string name, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", name, e, g);
        end
    endtask : chk

    // change pads and gather every event seen, then the events must have dropped
    task automatic watch(input logic [7:0] v, input logic [7:0] e);
        logic [7:0] acc;
        acc = 8'h00;
        @(negedge core_clk_i);
        ext_val = v;
        repeat (6) begin
            @(negedge core_clk_i);
            acc = acc | ev_o;
        end
        chk("change_event", e, acc);
        chk("event_idle", 8'h00, ev_o);
    endtask : watch

    task automatic done(input string t);
        $display("test %s done", t);
    endtask : done

    // the slave data input must not dip low while the synchroniser refills
    task automatic release_reset();
        logic seen;
        seen = 1'b1;
        rst_n_i = 1'b1;
        repeat (3) begin
            @(negedge core_clk_i);
            seen = seen & sda_o;
        end
        settle();
        chk("sda_idle", 8'h01, {7'h00, seen});
        chk("ioc", 8'h00, ioc_o);
        chk("wpu", 8'h00, wpu_o);
        chk("gpd", 8'h01, {7'h00, gpd_o});
        chk("ansel", 8'hff, ans_o);
        chk("dir", 8'hff, dir_o);
        chk("latch", 8'h00, lat_o);
        chk("value", 8'h00, val_o);
        chk("pullup", 8'h00, pad_pu);
        chk("oe", 8'h00, pad_oe);
        chk("dig_buf", 8'h00, buf_en);
        chk("events", 8'h00, ev_o);
    endtask : release_reset

    initial begin
        repeat (16) @(posedge core_clk_i);
        @(negedge core_clk_i);
        release_reset();
        done("reset");
        wr(IOC, 8'hff);
        wr(WPU, 8'hff);
        chk("ioc", 8'hf7, ioc_o);
        chk("wpu", 8'hf6, wpu_o);
        chk("pullup", 8'h00, pad_pu);
        wr(ANS, 8'h00);
        wr(GPD, 8'h00);
        chk("gpd", 8'h00, {7'h00, gpd_o});
        chk("pullup", 8'hf6, pad_pu);
        chk("dig_buf", 8'hff, buf_en);
        wr(DIR, 8'h0d);
        chk("dir", 8'h0d, dir_o);
        chk("pullup", 8'h04, pad_pu);
        wr(GPD, 8'h01);
        chk("pullup", 8'h00, pad_pu);
        wr(DIR, 8'hff);
        done("pullups");
        ext_val = 8'ha7;
        settle();
        chk("value", 8'ha7, val_o);
        wr(ANS, 8'hf0);
        chk("value", 8'h07, val_o);
        chk("dig_buf", 8'h0f, buf_en);
        wr(ANS, 8'h02);
        chk("value", 8'ha5, val_o);
        chk("adc4", 8'h01, {7'h00, adc4_o});
        wr(ANS, 8'h00);
        chk("adc4", 8'h00, {7'h00, adc4_o});
        done("reads");
        watch(8'h2e, 8'h81);
        wr(ANS, 8'h80);
        watch(8'haf, 8'h01);
        wr(ANS, 8'h00);
        done("events");
        ext_en = 8'h00;
        wr(LAT, 8'h3c);
        chk("latch", 8'h3c, lat_o);
        wr(DIR, 8'h00);
        chk("pad_out", 8'h3c, pad_out);
        chk("oe", 8'hff, pad_oe);
        wr(ANS, 8'hff);
        chk("value", 8'h00, val_o);
        chk("oe", 8'hff, pad_oe);
        chk("pad_out", 8'h3c, pad_out);
        chk("sda", 8'h00, {7'h00, sda_o});
        wr(ANS, 8'h00);
        chk("value", 8'h3c, val_o);
        done("outputs");
        wr(LAT, 8'h3d);
        chk("pad_out", 8'h3c, pad_out);
        chk("oe", 8'hfe, pad_oe);
        chk("sda", 8'h01, {7'h00, sda_o});
        i2c_en = 1'b1;
        i2c_low = 1'b1;
        settle();
        chk("oe", 8'hff, pad_oe);
        chk("sda", 8'h00, {7'h00, sda_o});
        i2c_low = 1'b0;
        smbus = 1'b1;
        settle();
        chk("oe", 8'hfe, pad_oe);
        chk("smbus", 8'h01, {7'h00, smb_o});
        wr(LAT, 8'h3c);
        chk("oe", 8'hfe, pad_oe);
        i2c_en = 1'b0;
        smbus = 1'b0;
        settle();
        chk("oe", 8'hff, pad_oe);
        chk("smbus", 8'h00, {7'h00, smb_o});
        done("pin_zero");
        @(negedge core_clk_i);
        rst_n_i = 1'b0;
        repeat (2) @(negedge core_clk_i);
        release_reset();
        done("reset_again");
        give_verdict();
    end
endmodule : pbc_port_b_bench
